/* File: verilog/icg_pkg.sv */
// constants, carriers and state types of the indexed configuration gpio port
package icg_pkg;
	// host i/o addresses of the two ports
	localparam logic [15:0] ICG_INDEX_PORT_ADDR = 16'h002e;
	localparam logic [15:0] ICG_DATA_PORT_ADDR = 16'h002f;
	// key values written to the index port
	localparam logic [7:0] ICG_KEY_ENTER = 8'h87;
	localparam logic [7:0] ICG_KEY_EXIT = 8'haa;
	// configuration register indices
	localparam logic [7:0] ICG_IDX_LDN = 8'h07;
	localparam logic [7:0] ICG_IDX_DIR = 8'hf0;
	localparam logic [7:0] ICG_IDX_VAL = 8'hf1;
	localparam logic [7:0] ICG_IDX_INV = 8'hf2;
	// reset values
	localparam logic [7:0] ICG_DIR_RST = 8'hff;
	localparam logic [7:0] ICG_VAL_RST = 8'h00;
	localparam logic [7:0] ICG_INV_RST = 8'h00;
	localparam logic [7:0] ICG_LDN_RST = 8'h00;
	localparam logic [7:0] ICG_IDX_RST = 8'h00;
	// default logical device number of the gpio function
	localparam logic [7:0] ICG_GPIO_LDN_DEF = 8'h07;
	// value read back when nothing answers
	localparam logic [7:0] ICG_IDLE_READ = 8'hff;
	localparam logic [7:0] ICG_UNMAPPED_READ = 8'h00;

	// one host i/o cycle, strobes last one clock
	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} icg_io_req_t;

	// state of the main block
	typedef struct packed {
		logic cfg_mode;
		logic key_seen;
		logic [7:0] index;
		logic [7:0] ldn;
		logic [7:0] dir;
		logic [7:0] val;
		logic [7:0] inv;
		logic [7:0] pin_out;
		logic [7:0] pin_oe;
		logic [7:0] rdata;
		logic rvalid;
	} icg_state_t;

	// state of the pin synchroniser
	typedef struct packed {
		logic [7:0] s1;
		logic [7:0] s2;
	} icg_sync_t;
endpackage

/* File: verilog/icg_pin_sync.sv */
// two flip-flop synchroniser for the eight general pins
`timescale 1ns/1ps
module icg_pin_sync (
	input wire logic clk_i,             // system clock
	input wire logic rstn_i,            // async reset, active low
	input wire logic [7:0] pins_i,      // raw pin levels
	output logic [7:0] pins_o           // synchronised levels
);
	icg_pkg::icg_sync_t st_r;
	icg_pkg::icg_sync_t st_nxt;

	// first stage feeds only the second stage
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pins_i;
		st_nxt.s2 = st_r.s1;
	end

	// state register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pins_o = st_r.s2;
endmodule

/* File: verilog/icg_gpio_port.sv */
// indexed configuration gpio port: key sequence, index/data ports, eight pins
// Notes on behaviour
// [R01] write-only index port at 2eh
// [R02] read/write data port at 2fh
// [R03] two 87h index writes enter config
// [R04] aah index write leaves config mode
// [R05] index 07h selects logical device number
// [R06] software must pick correct gpio device number
// [R07] indices f0h f1h f2h reach gpio registers
// [R08] direction bit 1 input, resets ff
// [R09] value bits of inputs read-only, reset 0
// [R10] inversion bit inverts both directions, reset 0
// [R11] outside config mode data accesses ignored
// [R12] gpio registers change only when selected
`timescale 1ns/1ps
module icg_gpio_port #(
	parameter logic [7:0] GPIO_LDN = icg_pkg::ICG_GPIO_LDN_DEF // gpio device number
) (
	input wire logic clk_i,                  // system clock, 100 mhz
	input wire logic rstn_i,                 // async reset, active low
	input wire icg_pkg::icg_io_req_t io_req_i, // host i/o cycle
	output logic [7:0] io_rdata_o,           // read data
	output logic io_rvalid_o,                // read data valid pulse
	output logic cfg_mode_o,                 // extended config mode active
	input wire logic [7:0] general_pins_i,   // pin levels in
	output logic [7:0] general_pins_o,       // pin levels driven
	output logic [7:0] general_pins_oe_o     // pin output enables
);
	icg_pkg::icg_state_t st_r;
	icg_pkg::icg_state_t st_nxt;
	logic [7:0] pins_sync;
	logic idx_wr;
	logic dat_wr;
	logic dat_rd;
	logic gpio_sel;
	logic [7:0] pin_in_view;

	// true when the cycle hits the given port
	function automatic logic hits(input logic [15:0] addr, input logic [15:0] port);
		hits = (addr == port);
	endfunction

	// pins from outside are synchronised first
	icg_pin_sync u_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.pins_i(general_pins_i),
		.pins_o(pins_sync)
	);

	// port decode
	// [R01] index port decode
	assign idx_wr = io_req_i.wr && hits(io_req_i.addr, icg_pkg::ICG_INDEX_PORT_ADDR);
	// [R02] data port decode
	assign dat_wr = io_req_i.wr && hits(io_req_i.addr, icg_pkg::ICG_DATA_PORT_ADDR);
	assign dat_rd = io_req_i.rd && hits(io_req_i.addr, icg_pkg::ICG_DATA_PORT_ADDR);
	// [R12] gpio device selected
	assign gpio_sel = (st_r.ldn == GPIO_LDN);
	// [R10] inbound pins seen through the inversion
	assign pin_in_view = pins_sync ^ st_r.inv;

	// next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.rvalid = 1'b0;
		// key sequence and index handling
		if (idx_wr) begin
			if (io_req_i.wdata == icg_pkg::ICG_KEY_EXIT) begin
				// [R04] leave config mode
				st_nxt.cfg_mode = 1'b0;
				st_nxt.key_seen = 1'b0;
			end else if (!st_r.cfg_mode) begin
				// [R03] second key enters, other writes keep the first
				if (io_req_i.wdata == icg_pkg::ICG_KEY_ENTER) begin
					st_nxt.cfg_mode = st_r.key_seen;
					st_nxt.key_seen = 1'b1;
				end
			end else begin
				// [R01] index chooses the data port target
				st_nxt.index = io_req_i.wdata;
			end
		end
		// data port writes
		// [R11] only inside config mode
		if (dat_wr && st_r.cfg_mode) begin
			if (st_r.index == icg_pkg::ICG_IDX_LDN) begin
				// [R05] logical device number
				st_nxt.ldn = io_req_i.wdata;
			end else if (gpio_sel && st_r.index == icg_pkg::ICG_IDX_DIR) begin
				// [R07] direction register
				st_nxt.dir = io_req_i.wdata;
			end else if (gpio_sel && st_r.index == icg_pkg::ICG_IDX_VAL) begin
				// [R09] input bits keep their value
				st_nxt.val = (st_r.val & st_r.dir) | (io_req_i.wdata & ~st_r.dir);
			end else if (gpio_sel && st_r.index == icg_pkg::ICG_IDX_INV) begin
				// [R07] inversion register
				st_nxt.inv = io_req_i.wdata;
			end
		end
		// data port reads
		if (dat_rd) begin
			st_nxt.rvalid = 1'b1;
			if (!st_r.cfg_mode) begin
				st_nxt.rdata = icg_pkg::ICG_IDLE_READ;
			end else if (st_r.index == icg_pkg::ICG_IDX_LDN) begin
				st_nxt.rdata = st_r.ldn;
			end else if (gpio_sel && st_r.index == icg_pkg::ICG_IDX_DIR) begin
				st_nxt.rdata = st_r.dir;
			end else if (gpio_sel && st_r.index == icg_pkg::ICG_IDX_VAL) begin
				// [R09] outputs read the register, inputs the pin
				st_nxt.rdata = (st_r.val & ~st_r.dir) | (pin_in_view & st_r.dir);
			end else if (gpio_sel && st_r.index == icg_pkg::ICG_IDX_INV) begin
				st_nxt.rdata = st_r.inv;
			end else begin
				st_nxt.rdata = icg_pkg::ICG_UNMAPPED_READ;
			end
		end
		// [R10] outbound value inverted
		st_nxt.pin_out = st_r.val ^ st_r.inv;
		// [R08] direction 0 drives the pin
		st_nxt.pin_oe = ~st_r.dir;
	end

	// state register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r.cfg_mode <= 1'b0;
			st_r.key_seen <= 1'b0;
			st_r.index <= icg_pkg::ICG_IDX_RST;
			st_r.ldn <= icg_pkg::ICG_LDN_RST;
			st_r.dir <= icg_pkg::ICG_DIR_RST;
			st_r.val <= icg_pkg::ICG_VAL_RST;
			st_r.inv <= icg_pkg::ICG_INV_RST;
			st_r.pin_out <= icg_pkg::ICG_VAL_RST ^ icg_pkg::ICG_INV_RST;
			st_r.pin_oe <= ~icg_pkg::ICG_DIR_RST;
			st_r.rdata <= icg_pkg::ICG_IDLE_READ;
			st_r.rvalid <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign io_rdata_o = st_r.rdata;
	assign io_rvalid_o = st_r.rvalid;
	assign cfg_mode_o = st_r.cfg_mode;
	assign general_pins_o = st_r.pin_out;
	assign general_pins_oe_o = st_r.pin_oe;

	// checks on the key sequence, index, registers and pins
	enter_mode_a: assert property ( // [R03]
		@(posedge clk_i) disable iff (!rstn_i)
		(idx_wr && io_req_i.wdata == icg_pkg::ICG_KEY_ENTER && st_r.key_seen && !st_r.cfg_mode)
		|=> st_r.cfg_mode)
		else $error("second key write did not enter config mode");
	single_key_a: assert property ( // [R03]
		@(posedge clk_i) disable iff (!rstn_i)
		(idx_wr && !st_r.key_seen && !st_r.cfg_mode) |=> !st_r.cfg_mode)
		else $error("config mode entered on a single key");
	exit_mode_a: assert property ( // [R04]
		@(posedge clk_i) disable iff (!rstn_i)
		(idx_wr && io_req_i.wdata == icg_pkg::ICG_KEY_EXIT) |=> !st_r.cfg_mode && !st_r.key_seen)
		else $error("exit key did not leave config mode");
	index_store_a: assert property ( // [R01]
		@(posedge clk_i) disable iff (!rstn_i)
		(idx_wr && st_r.cfg_mode && io_req_i.wdata != icg_pkg::ICG_KEY_EXIT)
		|=> st_r.index == $past(io_req_i.wdata))
		else $error("index write not stored");
	ldn_write_a: assert property ( // [R05]
		@(posedge clk_i) disable iff (!rstn_i)
		(dat_wr && st_r.cfg_mode && st_r.index == icg_pkg::ICG_IDX_LDN)
		|=> st_r.ldn == $past(io_req_i.wdata))
		else $error("device number write lost");
	dir_read_a: assert property ( // [R07]
		@(posedge clk_i) disable iff (!rstn_i)
		(dat_rd && st_r.cfg_mode && gpio_sel && st_r.index == icg_pkg::ICG_IDX_DIR)
		|=> io_rvalid_o && io_rdata_o == $past(st_r.dir))
		else $error("direction readback wrong");
	pin_enable_a: assert property ( // [R08]
		@(posedge clk_i) disable iff (!rstn_i)
		##1 general_pins_oe_o == ~$past(st_r.dir))
		else $error("output enable does not follow direction");
	input_bits_a: assert property ( // [R09]
		@(posedge clk_i) disable iff (!rstn_i)
		dat_wr |=> (st_r.val & $past(st_r.dir)) == ($past(st_r.val) & $past(st_r.dir)))
		else $error("input bit of value register changed");
	invert_out_a: assert property ( // [R10]
		@(posedge clk_i) disable iff (!rstn_i)
		##1 general_pins_o == ($past(st_r.val) ^ $past(st_r.inv)))
		else $error("driven pin value not inverted as set");
	nocfg_hold_a: assert property ( // [R11]
		@(posedge clk_i) disable iff (!rstn_i)
		(!st_r.cfg_mode) |=> $stable(st_r.dir) && $stable(st_r.val) && $stable(st_r.inv)
		&& $stable(st_r.ldn))
		else $error("register changed outside config mode");
	other_ldn_a: assert property ( // [R12]
		@(posedge clk_i) disable iff (!rstn_i)
		(!gpio_sel) |=> $stable(st_r.dir) && $stable(st_r.val) && $stable(st_r.inv))
		else $error("gpio register changed while not selected");

	// checks on read answers, the key sequence and gpio register writes
	read_pulse_a: assert property ( // [R02]
		@(posedge clk_i) disable iff (!rstn_i)
		dat_rd |=> io_rvalid_o)
		else $error("data port read not answered");
	no_answer_a: assert property ( // [R01]
		@(posedge clk_i) disable iff (!rstn_i)
		!dat_rd |=> !io_rvalid_o)
		else $error("read answer without a data port read");
	idle_read_a: assert property ( // [R11]
		@(posedge clk_i) disable iff (!rstn_i)
		(dat_rd && !st_r.cfg_mode) |=> io_rdata_o == icg_pkg::ICG_IDLE_READ)
		else $error("read outside config mode not the idle value");
	key_hold_a: assert property ( // [R03]
		@(posedge clk_i) disable iff (!rstn_i)
		(idx_wr && !st_r.cfg_mode && io_req_i.wdata != icg_pkg::ICG_KEY_ENTER
		&& io_req_i.wdata != icg_pkg::ICG_KEY_EXIT) |=> $stable(st_r.key_seen)
		&& !st_r.cfg_mode)
		else $error("other index write disturbed the key sequence");
	dir_write_a: assert property ( // [R07]
		@(posedge clk_i) disable iff (!rstn_i)
		(dat_wr && st_r.cfg_mode && gpio_sel && st_r.index == icg_pkg::ICG_IDX_DIR)
		|=> st_r.dir == $past(io_req_i.wdata))
		else $error("direction write lost");
	out_bits_a: assert property ( // [R09]
		@(posedge clk_i) disable iff (!rstn_i)
		(dat_wr && st_r.cfg_mode && gpio_sel && st_r.index == icg_pkg::ICG_IDX_VAL)
		|=> (st_r.val & ~$past(st_r.dir)) == ($past(io_req_i.wdata) & ~$past(st_r.dir)))
		else $error("output bit of value register not written");
	inv_write_a: assert property ( // [R10]
		@(posedge clk_i) disable iff (!rstn_i)
		(dat_wr && st_r.cfg_mode && gpio_sel && st_r.index == icg_pkg::ICG_IDX_INV)
		|=> st_r.inv == $past(io_req_i.wdata))
		else $error("inversion write lost");
	val_read_a: assert property ( // [R09]
		@(posedge clk_i) disable iff (!rstn_i)
		(dat_rd && st_r.cfg_mode && gpio_sel && st_r.index == icg_pkg::ICG_IDX_VAL)
		|=> io_rdata_o == (($past(st_r.val) & ~$past(st_r.dir))
		| (($past(pins_sync) ^ $past(st_r.inv)) & $past(st_r.dir))))
		else $error("value readback does not mix register and pins");
endmodule

/* File: testbench/tb.sv */
// self-checking bench of the indexed configuration gpio port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	icg_pkg::icg_io_req_t io_req_i = '0;
	logic [7:0] general_pins_i = 8'h00;
	logic [7:0] io_rdata_o, general_pins_o, general_pins_oe_o;
	logic io_rvalid_o, cfg_mode_o;
	int err_total = 0;
	int n_tests = 0;
	integer seed = 32'hdbe1;
	logic [7:0] exp_q[$];
	logic [7:0] e, d, v, i, p;
	localparam logic [15:0] IA = icg_pkg::ICG_INDEX_PORT_ADDR;
	localparam logic [15:0] DA = icg_pkg::ICG_DATA_PORT_ADDR;

	icg_gpio_port i_dut (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.io_req_i(io_req_i),
		.io_rdata_o(io_rdata_o),
		.io_rvalid_o(io_rvalid_o),
		.cfg_mode_o(cfg_mode_o),
		.general_pins_i(general_pins_i),
		.general_pins_o(general_pins_o),
		.general_pins_oe_o(general_pins_oe_o)
	);

	// 100 mhz clock
	initial begin
		forever #5 clk_i = ~clk_i;
	end

	// one strobe cycle, then idle
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] x);
		@(posedge clk_i);
		io_req_i <= '{a, w, ~w, x};
		@(posedge clk_i);
		io_req_i <= '0;
	endtask
	task automatic iw(input logic [7:0] x);
		acc(1'b1, IA, x);
	endtask
	task automatic rd(input logic [7:0] x);
		exp_q.push_back(x);
		acc(1'b0, DA, 8'h00);
	endtask
	task automatic wreg(input logic [7:0] idx, input logic [7:0] x);
		iw(idx);
		acc(1'b1, DA, x);
	endtask
	task automatic rr(input logic [7:0] idx, input logic [7:0] x);
		iw(idx);
		rd(x);
	endtask

	// read answers are matched against the oldest note
	always @(negedge clk_i) begin
		if (io_rvalid_o === 1'b1) begin
			e = (exp_q.size() == 0) ? ~io_rdata_o : exp_q.pop_front();
			`CHK("rdata", e, io_rdata_o)
		end
	end

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// hang guard
	initial begin
		#200us;
		err_total++;
		results();
	end

	// main sequence
	initial begin
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(negedge clk_i);
		`CHK("oe", 8'h00, general_pins_oe_o)
		`CHK("cfg", 1'b0, cfg_mode_o)
		// index port never answers a read
		acc(1'b0, IA, 8'h00);
		rd(icg_pkg::ICG_IDLE_READ);
		// key sequence, exit key cancels
		iw(8'h87);
		iw(8'haa);
		iw(8'h87);
		@(negedge clk_i);
		`CHK("cfg", 1'b0, cfg_mode_o)
		iw(8'h07);
		iw(8'h87);
		@(negedge clk_i);
		`CHK("cfg", 1'b1, cfg_mode_o)
		wreg(icg_pkg::ICG_IDX_LDN, 8'h09);
		wreg(icg_pkg::ICG_IDX_DIR, 8'h00);
		wreg(icg_pkg::ICG_IDX_INV, 8'h5a);
		rr(icg_pkg::ICG_IDX_DIR, 8'h00);
		rr(icg_pkg::ICG_IDX_LDN, 8'h09);
		wreg(icg_pkg::ICG_IDX_LDN, icg_pkg::ICG_GPIO_LDN_DEF);
		rr(icg_pkg::ICG_IDX_DIR, 8'hff);
		rr(icg_pkg::ICG_IDX_VAL, 8'h00);
		rr(icg_pkg::ICG_IDX_INV, 8'h00);
		rr(8'h55, icg_pkg::ICG_UNMAPPED_READ);
		for (int k = 0; k < 6; k++) begin
			p = 8'($random(seed));
			d = (k == 0) ? 8'h00 : (k == 5) ? 8'hff : 8'($random(seed));
			v = 8'($random(seed));
			i = 8'($random(seed));
			@(posedge clk_i);
			general_pins_i <= p;
			wreg(icg_pkg::ICG_IDX_DIR, d);
			wreg(icg_pkg::ICG_IDX_INV, i);
			wreg(icg_pkg::ICG_IDX_VAL, v);
			rr(icg_pkg::ICG_IDX_DIR, d);
			rr(icg_pkg::ICG_IDX_VAL, (v & ~d) | ((p ^ i) & d));
			rr(icg_pkg::ICG_IDX_INV, i);
			repeat (2) @(negedge clk_i);
			`CHK("oe", ~d, general_pins_oe_o)
			`CHK("pins", (v ^ i) & ~d, general_pins_o & ~d)
		end
		iw(icg_pkg::ICG_KEY_EXIT);
		@(negedge clk_i);
		`CHK("cfg", 1'b0, cfg_mode_o)
		wreg(icg_pkg::ICG_IDX_DIR, ~d);
		rr(icg_pkg::ICG_IDX_DIR, icg_pkg::ICG_IDLE_READ);
		iw(icg_pkg::ICG_KEY_ENTER);
		iw(icg_pkg::ICG_KEY_ENTER);
		wreg(icg_pkg::ICG_IDX_LDN, icg_pkg::ICG_GPIO_LDN_DEF);
		rr(icg_pkg::ICG_IDX_DIR, d);
		repeat (3) @(negedge clk_i);
		`CHK("oe", ~d, general_pins_oe_o)
		`CHK("pending", 0, exp_q.size())
		results();
	end
endmodule
